/* common/sflt_defs.svh */
// Purpose: Shared constants for the serial flash link and its host.
// Assumes: 20 MHz system clock, SPI mode 0 link clocked by the host.
// Notes: Cycle counts derive from the printed times; limits round up.
// Behaviour
// - Device launches on falling, samples on rising
// - Host captures device bit at next falling
// - Host drives on rising; device samples next rising
// - Read 0x0B clock at most 85/50 MHz
// - Read 0x03 clock at most 50/40 MHz
// - Read 0x1B clock at most 104/66 MHz
// - Page to buffer transfer within 180 us
// - Page to buffer compare within 180 us
// - Ultra-deep power-down entered within 3 us
// - Host wakes ultra-deep with 20 ns select low
// - Ultra-deep exit takes 100 us; host waits
// - Deep power-down entered within 2 us
// - Deep resume takes 35 us; host waits
// - Sector lockdown freeze within 200 us
// - Protection on within 1 us of WP low
// - Protection off within 1 us of WP high
// - Page erase and program within 35 ms
// - OTP register program within 500 us
`ifndef SFLT_DEFS_SVH
`define SFLT_DEFS_SVH

`define SFLT_CLK_MHZ 20
`define SFLT_SYNC_LAT 3
`define SFLT_TMR_W 20

`define SFLT_OP_RD_FAST 8'h0B
`define SFLT_OP_RD_SLOW 8'h03
`define SFLT_OP_RD_HIGH 8'h1B
`define SFLT_OP_STATUS 8'h05
`define SFLT_OP_XFER 8'h10
`define SFLT_OP_COMP 8'h11
`define SFLT_OP_EP 8'h12
`define SFLT_OP_OTP 8'h13
`define SFLT_OP_LOCK 8'h14
`define SFLT_OP_DPD 8'h20
`define SFLT_OP_RESUME 8'h21
`define SFLT_OP_UDPD 8'h22
`define SFLT_OP_WAKE 8'h00

`define SFLT_ST_RDY 7
`define SFLT_ST_LOCK 6
`define SFLT_ST_PROT 5
`define SFLT_ST_DPD 4

`define SFLT_FMAX_0B_HI 85
`define SFLT_FMAX_0B_FULL 50
`define SFLT_FMAX_03_HI 50
`define SFLT_FMAX_03_FULL 40
`define SFLT_FMAX_1B_HI 104
`define SFLT_FMAX_1B_FULL 66

`define SFLT_T_XFR_US 180
`define SFLT_T_COMP_US 180
`define SFLT_T_EUDPD_US 3
`define SFLT_T_XUDPD_US 100
`define SFLT_T_EDPD_US 2
`define SFLT_T_RDPD_US 35
`define SFLT_T_LOCK_US 200
`define SFLT_T_EP_MS 35
`define SFLT_T_OTP_US 500
`define SFLT_T_CSLU_NS 20
`define SFLT_T_CSH_NS 30

`define SFLT_CYC_XFR (`SFLT_T_XFR_US * `SFLT_CLK_MHZ)
`define SFLT_CYC_COMP (`SFLT_T_COMP_US * `SFLT_CLK_MHZ)
`define SFLT_CYC_EUDPD (`SFLT_T_EUDPD_US * `SFLT_CLK_MHZ)
`define SFLT_CYC_XUDPD (`SFLT_T_XUDPD_US * `SFLT_CLK_MHZ)
`define SFLT_CYC_EDPD (`SFLT_T_EDPD_US * `SFLT_CLK_MHZ)
`define SFLT_CYC_RDPD (`SFLT_T_RDPD_US * `SFLT_CLK_MHZ)
`define SFLT_CYC_LOCK (`SFLT_T_LOCK_US * `SFLT_CLK_MHZ)
`define SFLT_CYC_EP (`SFLT_T_EP_MS * 1000 * `SFLT_CLK_MHZ)
`define SFLT_CYC_OTP (`SFLT_T_OTP_US * `SFLT_CLK_MHZ)
`define SFLT_CYC_CSLU ((`SFLT_T_CSLU_NS * `SFLT_CLK_MHZ + 999) / 1000)
`define SFLT_CYC_CSH ((`SFLT_T_CSH_NS * `SFLT_CLK_MHZ + 999) / 1000)

`endif

/* common/sflt_pkg.sv */
// Purpose: Types shared by both link ends.
// Assumes: Constants come from sflt_defs.svh.
// Notes: One-hot state codes.
package sflt_pkg;
   typedef logic [7:0] sflt_byte_t;
   typedef enum logic [2:0] {
      PW_ACT = 3'b001,
      PW_DPD = 3'b010,
      PW_UDPD = 3'b100
   } sflt_pwr_e;
   typedef enum logic [2:0] {
      H_IDLE = 3'b001,
      H_WAKE = 3'b010,
      H_SHIFT = 3'b100
   } sflt_hst_e;
endpackage

/* common/sflt_link_if.sv */
// Purpose: Pins between host and flash device.
// Assumes: Device data line has a pull-up when not driven.
// Notes: No clocking block; the host makes the link clock.
`timescale 1ns/1ps
interface sflt_link_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic wp_n;
   logic miso_drv;
   logic miso_oe;
   logic miso;
   assign miso = miso_oe ? miso_drv : 1'b1;
   modport host (output sck, output cs_n, output mosi, output wp_n, input miso);
   modport dev (input sck, input cs_n, input mosi, input wp_n, output miso_drv, output miso_oe);
endinterface

/* rtl/sflt_fifo.sv */
// Purpose: Read data buffer between user logic and the link.
// Assumes: Depth is a power of two.
// Notes: Extra pointer bit separates full from empty.
`timescale 1ns/1ps
module sflt_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_chk
      $error("sflt_fifo: depth must be a power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic full;
   assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign in_ready_o = ~full;
   assign out_valid_o = wr_ptr != rd_ptr;
   assign out_data_o = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge clock_i) begin
      if (in_valid_i && !full) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         wr_ptr <= '0;
      end else if (in_valid_i && !full) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rd_ptr <= '0;
      end else if (out_ready_i && out_valid_o) begin
         rd_ptr <= rd_ptr + 1'b1;
      end
   end
endmodule

/* rtl/sflt_dev.sv */
// Purpose: Flash device end: serial shifter, power states, op timers.
// Assumes: Mode 0 link; link pins come from another domain.
// Notes: Timers run at their maximum, less the pin sync latency.
`timescale 1ns/1ps
`include "sflt_defs.svh"
module sflt_dev #(
   parameter int unsigned EP_CYC = `SFLT_CYC_EP,
   parameter int unsigned OTP_CYC = `SFLT_CYC_OTP,
   parameter int unsigned FIFO_DEPTH = 16
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   sflt_link_if.dev link,
   input wire logic rd_valid_i,
   output logic rd_ready_o,
   input wire logic [7:0] rd_data_i,
   output logic busy_o,
   output logic prot_o,
   output logic locked_o,
   output logic [2:0] pwr_o,
   output logic op_done_o,
   output logic [7:0] op_code_o
);
   if (EP_CYC <= `SFLT_SYNC_LAT || EP_CYC >= (1 << `SFLT_TMR_W)
       || OTP_CYC <= `SFLT_SYNC_LAT || OTP_CYC >= (1 << `SFLT_TMR_W)) begin : g_chk
      $error("sflt_dev: timer counts out of range");
   end

   function automatic logic [`SFLT_TMR_W-1:0] ld(input int unsigned c);
      ld = `SFLT_TMR_W'(c - `SFLT_SYNC_LAT);
   endfunction

   logic [1:0] sck_s;
   logic [1:0] cs_s;
   logic [1:0] mosi_s;
   logic [1:0] wp_s;
   logic sck_q;
   logic cs_q;
   logic mosi_q;
   logic rise;
   logic fall;
   logic cs_fall;
   logic cs_rise;
   logic [2:0] bitc;
   logic have_op;
   sflt_pkg::sflt_byte_t rx_sr;
   sflt_pkg::sflt_byte_t opcode;
   sflt_pkg::sflt_byte_t tx_sr;
   sflt_pkg::sflt_byte_t status;
   sflt_pkg::sflt_byte_t fifo_data;
   logic fifo_valid;
   logic pop;
   logic is_read;
   logic load;
   logic go;
   sflt_pkg::sflt_pwr_e pwr;
   logic [`SFLT_TMR_W-1:0] tmr;
   sflt_pkg::sflt_byte_t pend;

   // Two flops per pin; logic reads the second stage, plus a one-cycle delayed copy of it for every pin but WP
   // Host moves data at the rise itself, so the bit taken is the one held before it
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         sck_s <= 2'h0;
         cs_s <= 2'h3;
         mosi_s <= 2'h0;
         wp_s <= 2'h3;
         sck_q <= 1'b0;
         cs_q <= 1'b1;
         mosi_q <= 1'b0;
      end else begin
         sck_s <= {sck_s[0], link.sck};
         cs_s <= {cs_s[0], link.cs_n};
         mosi_s <= {mosi_s[0], link.mosi};
         wp_s <= {wp_s[0], link.wp_n};
         sck_q <= sck_s[1];
         cs_q <= cs_s[1];
         mosi_q <= mosi_s[1];
      end
   end

   assign rise = ~cs_s[1] & sck_s[1] & ~sck_q;
   assign fall = ~cs_s[1] & ~sck_s[1] & sck_q;
   assign cs_fall = ~cs_s[1] & cs_q;
   assign cs_rise = cs_s[1] & ~cs_q;
   assign busy_o = tmr != '0;
   assign is_read = opcode == `SFLT_OP_RD_FAST || opcode == `SFLT_OP_RD_SLOW
                    || opcode == `SFLT_OP_RD_HIGH;
   assign load = fall & have_op & (bitc == 3'h0);
   assign pop = load & is_read & (pwr == sflt_pkg::PW_ACT);
   assign pwr_o = pwr;

   // Incoming bits are taken on the rising link edge
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || cs_fall) begin
         bitc <= 3'h0;
         have_op <= 1'b0;
         rx_sr <= 8'h00;
         opcode <= 8'h00;
      end else if (rise) begin
         rx_sr <= {rx_sr[6:0], mosi_q};
         bitc <= bitc + 3'h1;
         if (bitc == 3'h7 && !have_op) begin
            opcode <= {rx_sr[6:0], mosi_q};
            have_op <= 1'b1;
         end
      end
   end

   always_comb begin
      status = 8'h00;
      status[`SFLT_ST_RDY] = ~busy_o;
      status[`SFLT_ST_LOCK] = locked_o;
      status[`SFLT_ST_PROT] = prot_o;
      status[`SFLT_ST_DPD] = pwr == sflt_pkg::PW_DPD;
   end

   // Outgoing bits change only on the falling link edge
   // Line flop loads with the shifter; one more stage would let a bit move after the next rise
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || cs_fall) begin
         tx_sr <= 8'h00;
         link.miso_drv <= 1'b0;
      end else if (load) begin
         if (opcode == `SFLT_OP_STATUS && pwr != sflt_pkg::PW_UDPD) begin
            tx_sr <= status;
            link.miso_drv <= status[7];
         end else if (pop && fifo_valid) begin
            tx_sr <= fifo_data;
            link.miso_drv <= fifo_data[7];
         end else begin
            tx_sr <= 8'h00;
            link.miso_drv <= 1'b0;
         end
      end else if (fall) begin
         tx_sr <= {tx_sr[6:0], 1'b0};
         link.miso_drv <= tx_sr[6];
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         link.miso_oe <= 1'b0;
      end else begin
         link.miso_oe <= ~cs_s[1] & (pwr != sflt_pkg::PW_UDPD);
      end
   end

   // Ignored while busy; only resume is heard in deep power-down
   assign go = cs_rise & have_op & ~busy_o
               & (((pwr == sflt_pkg::PW_ACT) & (opcode != `SFLT_OP_RESUME))
                  | ((pwr == sflt_pkg::PW_DPD) & (opcode == `SFLT_OP_RESUME)));

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         tmr <= '0;
         pend <= `SFLT_OP_WAKE;
      end else if (tmr != '0) begin
         tmr <= tmr - 1'b1;
      end else if (pwr == sflt_pkg::PW_UDPD && cs_fall) begin
         tmr <= ld(`SFLT_CYC_XUDPD);
         pend <= `SFLT_OP_WAKE;
      end else if (go) begin
         pend <= opcode;
         unique case (opcode)
            `SFLT_OP_XFER: tmr <= ld(`SFLT_CYC_XFR);
            `SFLT_OP_COMP: tmr <= ld(`SFLT_CYC_COMP);
            `SFLT_OP_UDPD: tmr <= ld(`SFLT_CYC_EUDPD);
            `SFLT_OP_DPD: tmr <= ld(`SFLT_CYC_EDPD);
            `SFLT_OP_RESUME: tmr <= ld(`SFLT_CYC_RDPD);
            `SFLT_OP_LOCK: tmr <= ld(`SFLT_CYC_LOCK);
            `SFLT_OP_EP: tmr <= ld(EP_CYC);
            `SFLT_OP_OTP: tmr <= ld(OTP_CYC);
            default: tmr <= '0;
         endcase
      end
   end

   // Effects land as the timer expires
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         pwr <= sflt_pkg::PW_ACT;
         locked_o <= 1'b0;
         op_done_o <= 1'b0;
         op_code_o <= 8'h00;
      end else begin
         op_done_o <= 1'b0;
         if (tmr == `SFLT_TMR_W'(1)) begin
            op_done_o <= 1'b1;
            op_code_o <= pend;
            unique case (pend)
               `SFLT_OP_UDPD: pwr <= sflt_pkg::PW_UDPD;
               `SFLT_OP_DPD: pwr <= sflt_pkg::PW_DPD;
               `SFLT_OP_RESUME, `SFLT_OP_WAKE: pwr <= sflt_pkg::PW_ACT;
               `SFLT_OP_LOCK: locked_o <= 1'b1;
               default: pwr <= pwr;
            endcase
         end
      end
   end

   // Sync delay is three cycles, well inside one microsecond
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         prot_o <= 1'b0;
      end else begin
         prot_o <= ~wp_s[1];
      end
   end

   // Read data waits here; a stalled link backs up to the producer
   sflt_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .in_valid_i(rd_valid_i),
      .in_ready_o(rd_ready_o),
      .in_data_i(rd_data_i),
      .out_valid_o(fifo_valid),
      .out_ready_i(pop),
      .out_data_o(fifo_data)
   );
endmodule

/* rtl/sflt_host.sv */
// Purpose: Host end: makes the link clock, frames one command per request.
// Assumes: Link clock well below the device's pin sync rate.
// Notes: Bytes after the opcode are sent as zero.
`timescale 1ns/1ps
`include "sflt_defs.svh"
module sflt_host #(
   parameter int unsigned DIV_HALF = 4
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   sflt_link_if.host link,
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire logic [7:0] cmd_op_i,
   input wire logic [7:0] cmd_len_i,
   input wire logic prot_req_i,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   output logic done_o
);
   // Slowest read ceiling bounds every command's clock
   if (DIV_HALF < 4 || DIV_HALF > 255
       || `SFLT_CLK_MHZ > 2 * DIV_HALF * `SFLT_FMAX_03_FULL) begin : g_chk
      $error("sflt_host: link clock divider out of range");
   end

   logic [1:0] miso_s;
   sflt_pkg::sflt_hst_e state;
   logic [7:0] hc;
   logic tick;
   logic [6:0] tx_sr;
   logic [11:0] fc;
   logic [11:0] total;
   logic [`SFLT_TMR_W-1:0] gap;
   logic asleep;
   sflt_pkg::sflt_byte_t op_q;
   sflt_pkg::sflt_byte_t rx_sr;
   logic fall_ev;

   assign tick = hc == 8'(DIV_HALF - 1);
   assign fall_ev = (state == sflt_pkg::H_SHIFT) & tick & link.sck;
   assign cmd_ready_o = (state == sflt_pkg::H_IDLE) & (gap == '0) & ~asleep;

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         miso_s <= 2'h3;
         link.wp_n <= 1'b1;
      end else begin
         miso_s <= {miso_s[0], link.miso};
         link.wp_n <= ~prot_req_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state <= sflt_pkg::H_IDLE;
         link.cs_n <= 1'b1;
         link.sck <= 1'b0;
         link.mosi <= 1'b0;
         hc <= 8'h00;
         tx_sr <= 7'h00;
         fc <= 12'h000;
         total <= 12'h000;
         gap <= '0;
         asleep <= 1'b0;
         op_q <= 8'h00;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         unique case (state)
            sflt_pkg::H_IDLE: begin
               if (gap != '0) begin
                  gap <= gap - 1'b1;
               end else if (cmd_valid_i && asleep) begin
                  link.cs_n <= 1'b0;
                  // One spare cycle so the far end's pin sync cannot miss the pulse
                  gap <= `SFLT_TMR_W'(`SFLT_CYC_CSLU + 1);
                  state <= sflt_pkg::H_WAKE;
               end else if (cmd_valid_i) begin
                  link.cs_n <= 1'b0;
                  link.mosi <= cmd_op_i[7];
                  tx_sr <= cmd_op_i[6:0];
                  op_q <= cmd_op_i;
                  total <= 12'((cmd_len_i + 12'h001) << 3);
                  fc <= 12'h000;
                  hc <= 8'h00;
                  state <= sflt_pkg::H_SHIFT;
               end
            end
            sflt_pkg::H_WAKE: begin
               if (gap > `SFLT_TMR_W'(1)) begin
                  gap <= gap - 1'b1;
               end else begin
                  link.cs_n <= 1'b1;
                  asleep <= 1'b0;
                  gap <= `SFLT_TMR_W'(`SFLT_CYC_XUDPD);
                  state <= sflt_pkg::H_IDLE;
               end
            end
            sflt_pkg::H_SHIFT: begin
               hc <= tick ? 8'h00 : hc + 8'h01;
               if (tick) begin
                  link.sck <= ~link.sck;
                  if (!link.sck) begin
                     link.mosi <= tx_sr[6];
                     tx_sr <= {tx_sr[5:0], 1'b0};
                  end else begin
                     fc <= fc + 12'h001;
                     if (fc + 12'h001 == total) begin
                        link.cs_n <= 1'b1;
                        done_o <= 1'b1;
                        state <= sflt_pkg::H_IDLE;
                        asleep <= op_q == `SFLT_OP_UDPD;
                        if (op_q == `SFLT_OP_UDPD) begin
                           gap <= `SFLT_TMR_W'(`SFLT_CYC_EUDPD);
                        end else if (op_q == `SFLT_OP_DPD) begin
                           gap <= `SFLT_TMR_W'(`SFLT_CYC_EDPD);
                        end else if (op_q == `SFLT_OP_RESUME) begin
                           gap <= `SFLT_TMR_W'(`SFLT_CYC_RDPD);
                        end else begin
                           gap <= `SFLT_TMR_W'(`SFLT_CYC_CSH);
                        end
                     end
                  end
               end
            end
         endcase
      end
   end

   // A bit launched on one falling edge is taken on the next one
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         rx_sr <= 8'h00;
         rx_data_o <= 8'h00;
         rx_valid_o <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         if (fall_ev && fc >= 12'h008) begin
            rx_sr <= {rx_sr[6:0], miso_s[1]};
            if (fc[2:0] == 3'h7) begin
               rx_data_o <= {rx_sr[6:0], miso_s[1]};
               rx_valid_o <= 1'b1;
            end
         end
      end
   end
endmodule

/* bench/sflt_link_props.sv */
// Purpose: Wire checks on the host to device link.
// Assumes: One system clock samples every pin.
// Notes: Gaps allow two cycles for where the host starts its count.
`timescale 1ns/1ps
`include "sflt_defs.svh"
module sflt_link_props (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic wp_n,
   input wire logic miso_drv,
   input wire logic miso_oe,
   input wire logic miso
);
   localparam int GAP_UDPD = `SFLT_CYC_EUDPD - 2;
   localparam int GAP_RDPD = `SFLT_CYC_RDPD - 2;
   localparam int GAP_WAKE = `SFLT_CYC_XUDPD - 2;
   logic sck_q;
   logic mosi_q;
   logic [15:0] rises;
   logic [7:0] op_sh;
   logic [7:0] last_op;
   logic [15:0] gap;
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (sys_rst_i);
   always_ff @(posedge clock_i) begin
      sck_q <= sck;
      mosi_q <= mosi;
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i || cs_n) begin
         rises <= 16'h0000;
      end
      else if (sck && !sck_q) begin
         rises <= rises + 16'h0001;
      end
   end
   // Host changes data at the same rise, so the bit taken is the one before it
   always_ff @(posedge clock_i) begin
      if (!cs_n && sck && !sck_q && rises < 16'h0008) begin
         op_sh <= {op_sh[6:0], mosi_q};
      end
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         last_op <= 8'hFF;
      end
      else if ($rose(cs_n)) begin
         last_op <= (rises == 16'h0000) ? `SFLT_OP_WAKE : op_sh;
      end
   end
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         gap <= 16'hFFFF;
      end
      else if (!cs_n) begin
         gap <= 16'h0000;
      end
      else if (gap != 16'hFFFF) begin
         gap <= gap + 16'h0001;
      end
   end
   a_sck_idle_low: assert property (cs_n |-> !sck)
      else $error("Link clock high outside a frame");
   a_miso_fall_launch: assert property (!cs_n && miso_oe && $changed(miso_drv) |-> !sck && !$past(sck))
      else $error("Device data moved while link clock high");
   a_miso_hold_fall: assert property (!cs_n && miso_oe && $fell(sck) |-> $stable(miso_drv))
      else $error("Device data moved at host capture edge");
   a_miso_line_free: assert property (cs_n [*5] |-> !miso_oe)
      else $error("Device still drives data line after frame");
   a_mosi_on_rise: assert property (!cs_n && !$past(cs_n) && $changed(mosi) |-> $rose(sck))
      else $error("Host data changed away from a rise");
   a_mosi_hold_fall: assert property (!cs_n && $fell(sck) |-> $stable(mosi))
      else $error("Host data moved at a fall");
   a_frame_whole_bytes: assert property ($rose(cs_n) && rises != 16'h0000 |-> rises[2:0] == 3'h0)
      else $error("Frame ended on a partial byte");
   a_wake_low_time: assert property ($fell(cs_n) |=> !cs_n)
      else $error("Select low pulse too short");
   a_ultra_entry_gap: assert property ($fell(cs_n) && last_op == `SFLT_OP_UDPD |-> gap >= GAP_UDPD)
      else $error("Select fell too soon after ultra power-down");
   a_resume_gap: assert property ($fell(cs_n) && last_op == `SFLT_OP_RESUME |-> gap >= GAP_RDPD)
      else $error("Command too soon after resume");
   a_wake_exit_gap: assert property ($fell(cs_n) && last_op == `SFLT_OP_WAKE |-> gap >= GAP_WAKE)
      else $error("Command too soon after wake pulse");
endmodule

/* bench/tb.sv */
// Purpose: Runs host commands against the device and checks results.
// Assumes: Short program-time counts keep the run brief.
// Notes: Op and power time bounds count from the edge that raises select; protection bounds count from the WP request.
`timescale 1ns/1ps
`include "sflt_defs.svh"
module tb;
   localparam int EP_CYC = 200;
   localparam int OTP_CYC = 100;
   logic clock_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   logic [7:0] cmd_op = 8'h00;
   logic [7:0] cmd_len = 8'h00;
   logic prot_req = 1'b0;
   logic [7:0] rx_data;
   logic rx_valid;
   logic done;
   logic rd_valid = 1'b0;
   logic rd_ready;
   logic [7:0] rd_data = 8'h00;
   logic busy;
   logic prot;
   logic locked;
   logic [2:0] pwr;
   logic op_done;
   logic [7:0] op_code;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   logic [7:0] rxq [$];
   logic [7:0] t_op [5] = '{`SFLT_OP_XFER, `SFLT_OP_COMP, `SFLT_OP_EP, `SFLT_OP_OTP, `SFLT_OP_LOCK};
   int t_max [5] = '{`SFLT_CYC_XFR, `SFLT_CYC_COMP, EP_CYC, OTP_CYC, `SFLT_CYC_LOCK};
   logic [7:0] r_op [3] = '{`SFLT_OP_RD_FAST, `SFLT_OP_RD_SLOW, `SFLT_OP_RD_HIGH};
   int r_len [3] = '{4, 4, 8};
   sflt_link_if link ();
   sflt_host #(.DIV_HALF(4)) i_sflt_host (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .link(link),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_len_i(cmd_len),
      .prot_req_i(prot_req), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .done_o(done));
   sflt_dev #(.EP_CYC(EP_CYC), .OTP_CYC(OTP_CYC), .FIFO_DEPTH(16)) i_sflt_dev (.clock_i(clock_i),
      .sys_rst_i(sys_rst_i), .link(link), .rd_valid_i(rd_valid), .rd_ready_o(rd_ready), .rd_data_i(rd_data),
      .busy_o(busy), .prot_o(prot), .locked_o(locked), .pwr_o(pwr), .op_done_o(op_done), .op_code_o(op_code));
   sflt_link_props i_sflt_link_props (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sck(link.sck),
      .cs_n(link.cs_n), .mosi(link.mosi), .wp_n(link.wp_n), .miso_drv(link.miso_drv),
      .miso_oe(link.miso_oe), .miso(link.miso));
   initial begin
      forever #25 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
   end
   always @(negedge clock_i) begin
      if (rx_valid === 1'b1) begin
         rxq.push_back(rx_data);
      end
   end
   task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && n_compared > 0) begin
         $display("All checks passed");
      end
      else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Request held until taken; the host itself keeps its gaps after power ops
   task automatic send(input logic [7:0] op, input int len);
      int n;
      rxq.delete();
      @(negedge clock_i);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_len = 8'(len);
      for (n = 0; n < 5000 && cmd_ready !== 1'b1; n++) @(negedge clock_i);
      @(posedge clock_i);
      @(negedge clock_i);
      cmd_valid = 1'b0;
      for (n = 0; n < 20000 && done !== 1'b1; n++) @(negedge clock_i);
      chk_bit("frame_done", 1'b1, done);
      // Last byte lands on the same edge that ends the frame
      @(posedge clock_i);
   endtask
   task automatic status(input logic [7:0] exp);
      send(`SFLT_OP_STATUS, 1);
      chk_byte("status", exp, rxq[0]);
   endtask
   task automatic push(input logic [7:0] d);
      int n;
      @(negedge clock_i);
      rd_valid = 1'b1;
      rd_data = d;
      for (n = 0; n < 100 && rd_ready !== 1'b1; n++) @(negedge clock_i);
      @(posedge clock_i);
   endtask
   task automatic run_op(input logic [7:0] op, input int bound, input logic poll);
      int t0;
      send(op, 0);
      t0 = cyc;
      repeat (5) @(negedge clock_i);
      chk_bit("busy", 1'b1, busy);
      if (poll) begin
         status(8'h00);
      end
      while (op_done !== 1'b1 && cyc - t0 < bound) @(negedge clock_i);
      chk_bit("op_in_time", 1'b1, op_done);
      chk_byte("op_code", op, op_code);
   endtask
   task automatic wait_pwr(input logic [2:0] exp, input int bound);
      int t0;
      t0 = cyc;
      while (pwr !== exp && cyc - t0 < bound) @(negedge clock_i);
      chk_byte("power", {5'h00, exp}, {5'h00, pwr});
   endtask
   task automatic wait_prot(input logic exp);
      int t0;
      t0 = cyc;
      while (prot !== exp && cyc - t0 < 20) @(negedge clock_i);
      chk_bit("prot", exp, prot);
   endtask
   initial begin
      repeat (60000) @(posedge clock_i);
      fail_count++;
      wrap_up();
   end
   initial begin
      int k;
      repeat (10) @(posedge clock_i);
      @(negedge clock_i);
      sys_rst_i = 1'b0;
      chk_byte("power_reset", 8'h01, {5'h00, pwr});
      for (int i = 0; i < 16; i++) push(8'h30 + 8'(i));
      @(negedge clock_i);
      rd_valid = 1'b0;
      chk_bit("fifo_full", 1'b0, rd_ready);
      k = 0;
      for (int j = 0; j < 3; j++) begin
         send(r_op[j], r_len[j]);
         for (int b = 0; b < r_len[j]; b++) begin
            chk_byte("read_data", 8'h30 + 8'(k), rxq[b]);
            k++;
         end
      end
      send(`SFLT_OP_RD_FAST, 1);
      chk_byte("read_empty", 8'h00, rxq[0]);
      status(8'h80);
      for (int i = 0; i < 5; i++) run_op(t_op[i], t_max[i], i == 0);
      chk_bit("locked", 1'b1, locked);
      @(negedge clock_i);
      prot_req = 1'b1;
      wait_prot(1'b1);
      status(8'hE0);
      @(negedge clock_i);
      prot_req = 1'b0;
      wait_prot(1'b0);
      send(`SFLT_OP_DPD, 0);
      wait_pwr(3'b010, `SFLT_CYC_EDPD);
      status(8'hD0);
      send(`SFLT_OP_XFER, 0);
      repeat (8) @(posedge clock_i);
      chk_bit("deep_refuse", 1'b0, busy);
      send(`SFLT_OP_RESUME, 0);
      wait_pwr(3'b001, `SFLT_CYC_RDPD);
      send(`SFLT_OP_UDPD, 0);
      wait_pwr(3'b100, `SFLT_CYC_EUDPD);
      // Only a select pulse wakes it; the host sends one ahead of this frame
      status(8'hC0);
      wait_pwr(3'b001, 1);
      wrap_up();
   end
endmodule
